// ---- include/eic_pkg.sv ----
// Package for the external interrupt controller: addresses, fields, vectors
package eic_pkg;
    localparam logic [7:0] EIC_ADDR_POL  = 8'h92;
    localparam logic [7:0] EIC_ADDR_IE   = 8'hA8;
    localparam logic [7:0] EIC_ADDR_IP   = 8'hB8;
    localparam logic [7:0] EIC_RST_POL   = 8'h00;
    localparam logic [7:0] EIC_RST_IE    = 8'h00;
    localparam logic [7:0] EIC_RST_IP    = 8'h00;
    localparam int         EIC_GEN_BIT   = 7;
    localparam int         EIC_X2_BIT    = 6;
    localparam int         EIC_PIN_LSB   = 3;
    localparam int         EIC_TC_IT0    = 1;
    localparam int         EIC_TC_IT1    = 3;
    localparam int         EIC_NSRC      = 8;
    // Vectors in polling order: ext0, t0, ext1, t1, serial, t2, ext2, packetizer
    localparam logic [7:0] EIC_VEC_BASE  = 8'h03;
    localparam logic [7:0] EIC_VEC_STEP  = 8'h08;
    typedef enum logic [1:0] {
        EIC_IDLE = 2'b00,
        EIC_ACK  = 2'b01
    } eic_state_e;
endpackage

// ---- design/eic_ctrl.sv ----
// External interrupt controller: source capture, masking, priority and vectoring
`timescale 1ns/100ps
// Contract
// (RQ1) Arbitrate eight sources: three pins, three timers, serial, packetizer.
// (RQ2) Each source vectors to its fixed address 03h plus eight per index.
// (RQ3) Pins 0 and 1 edge or level triggered by timer control bits 1, 3.
// (RQ4) Pin 2 always edge triggered, falling or rising per polarity bit 2.
// (RQ5) Pin 2 flag clears in hardware when its interrupt is serviced.
// (RQ6) Enable register at 0A8h, resets 00h, global bit 7, source masks below.
// (RQ7) Enable bit 6 masks pin 2 interrupt; zero disables it.
// (RQ8) Packetizer interrupt masked by its own control bit 0, not enable register.
// (RQ9) Priority register at 0B8h, resets 00h, one bit per source.
// (RQ10) Priority bits 6, 7 raise pin 2 and packetizer to high level.
// (RQ11) Polarity register at 092h, byte addressable, resets 00h.
// (RQ12) Polarity bits 5:3 read raw pin levels, unaffected by polarity.
// (RQ13) Polarity bit zero selects falling edge, one selects rising edge.
// (RQ14) Polarity one makes level requests active high; timer pin signal inverted.
// (RQ15) Polarity register bits 7 and 6 read as zero.
// (RQ16) In power down an unmasked active pin edge requests oscillator wakeup.
// (RQ17) Same level requests resolve lowest vector first.
// (RQ18) Nothing is taken while global enable is zero.
module eic_ctrl
    import eic_pkg::*;
(
    input  wire logic       ref_clk,        // Processor clock
    input  wire logic       rst_n,          // Core reset, active low
    input  wire logic [2:0] ext_irq_pin,    // Raw pins ext_irq_pin_2..0
    input  wire logic       timer0_req,     // Timer 0 overflow flag
    input  wire logic       timer1_req,     // Timer 1 overflow flag
    input  wire logic       timer2_req,     // Timer 2 overflow or external flag
    input  wire logic       serial_req,     // Serial receive or transmit flag
    input  wire logic       pkt_req,        // Packetizer request
    input  wire logic       pkt_int_mask,   // Packetizer control bit 0
    input  wire logic [3:0] timer_control_register_mode,      // Timer control bits 3:0
    input  wire logic       power_down,     // Lowest power state active
    input  wire logic [7:0] sfr_addr,       // Special function address
    input  wire logic [7:0] sfr_wdata,      // Write data
    input  wire logic       sfr_we,         // Byte write strobe
    input  wire logic       sfr_bit_we,     // Bit write strobe
    input  wire logic [2:0] sfr_bit_sel,    // Bit number for bit write
    input  wire logic       sfr_bit_val,    // Bit value for bit write
    output logic      [7:0] sfr_rdata,      // Read data
    output logic            sfr_hit,        // Address maps here
    output logic            irq_req,        // Interrupt pending to core
    output logic      [7:0] irq_vector,     // Vector address of pending source
    output logic            irq_high,       // Pending source at high level
    input  wire logic       irq_ack,        // Core takes pending interrupt
    output logic      [1:0] ext_edge_req,   // Edge flags of pins 1:0 for timer control
    output logic      [2:0] ext_pin_int,    // Polarity adjusted pins to timer controls
    output logic            wake_req        // Oscillator restart request
);
    logic [7:0] ie_r, ip_r;
    logic [2:0] pol_r;
    logic [2:0] pin_d_r;
    logic [2:0] eflag_r, eflag_nxt;
    logic [7:0] vec_r;
    logic       req_r, high_r;
    logic       wake_r;
    eic_state_e state_r;

    function automatic logic [7:0] bit_upd(input logic [7:0] cur, input logic [7:0] addr);
        logic [7:0] v;
        v = cur;
        if (sfr_we && sfr_addr == addr)
            v = sfr_wdata;
        else if (sfr_bit_we && sfr_addr == addr)
            v[sfr_bit_sel] = sfr_bit_val;
        return v;
    endfunction

    function automatic logic [2:0] first_one(input logic [7:0] v);
        logic [2:0] idx;
        idx = 3'd0;
        for (int i = EIC_NSRC - 1; i >= 0; i--)
            if (v[i])
                idx = i[2:0];
        return idx;
    endfunction

    wire [2:0] pin_act  = ext_irq_pin ^ ~pol_r;  // High when pin is active  (see RQ13) (see RQ14)
    wire [2:0] pin_actd = pin_d_r ^ ~pol_r;
    wire [2:0] edge_hit = pin_act & ~pin_actd;   // (see RQ4) (see RQ13)
    wire       lvl0     = timer_control_register_mode[EIC_TC_IT0] == 1'b0;  // (see RQ3)
    wire       lvl1     = timer_control_register_mode[EIC_TC_IT1] == 1'b0;  // (see RQ3)
    wire       src_x0   = lvl0 ? pin_act[0] : eflag_r[0];
    wire       src_x1   = lvl1 ? pin_act[1] : eflag_r[1];
    // Order is the polling order, which is also vector order (see RQ1) (see RQ17)
    wire [7:0] raw_src  = {pkt_req, eflag_r[2], timer2_req, serial_req,
                           timer1_req, src_x1, timer0_req, src_x0};
    wire [7:0] src_mask = {pkt_int_mask, ie_r[6:0]};  // (see RQ7) (see RQ8)
    wire [7:0] enabled  = ie_r[EIC_GEN_BIT] ? (raw_src & src_mask) : 8'h00;  // (see RQ18)
    wire [7:0] hi_set   = enabled & ip_r;    // (see RQ9) (see RQ10)
    wire [7:0] lo_set   = enabled & ~ip_r;
    wire       any_hi   = |hi_set;
    wire [2:0] win_idx  = any_hi ? first_one(hi_set) : first_one(lo_set);  // (see RQ17)
    wire [7:0] win_vec  = EIC_VEC_BASE + {win_idx, 3'b000};  // (see RQ2)
    wire       take     = irq_ack && req_r && state_r == EIC_IDLE;
    wire [2:0] wmask    = {ie_r[EIC_X2_BIT], ie_r[2], ie_r[0]};

    // Service clear only touches the pin flag whose vector was handed out
    function automatic logic [2:0] vec_to_x(input logic [7:0] v);
        return (v == EIC_VEC_BASE) ? 3'b001 :
               (v == EIC_VEC_BASE + 8'h10) ? 3'b010 :
               (v == EIC_VEC_BASE + 8'h30) ? 3'b100 : 3'b000;
    endfunction

    always_comb begin
        eflag_nxt = eflag_r;
        if (take)
            eflag_nxt = eflag_r & ~vec_to_x(vec_r);  // (see RQ5)
        eflag_nxt = eflag_nxt | edge_hit;  // Set wins over service clear
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ie_r <= EIC_RST_IE;
        end else begin
            ie_r <= bit_upd(ie_r, EIC_ADDR_IE);  // (see RQ6)
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ip_r <= EIC_RST_IP;
        end else begin
            ip_r <= bit_upd(ip_r, EIC_ADDR_IP);  // (see RQ9)
        end
    end

    // Polarity takes byte writes only; bit writes to its address are dropped
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pol_r <= EIC_RST_POL[2:0];
        end else if (sfr_we && sfr_addr == EIC_ADDR_POL) begin
            pol_r <= sfr_wdata[2:0];  // (see RQ11)
        end
    end

    // History resets to the idle high level so reset release makes no false edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_d_r <= 3'b111;
        end else begin
            pin_d_r <= ext_irq_pin;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            eflag_r <= 3'b000;
        end else begin
            eflag_r <= eflag_nxt;
        end
    end

    // Request, vector and level outputs are registered so the vector never glitches under the core
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_r   <= 1'b0;
            state_r <= EIC_IDLE;
        end else begin
            req_r   <= |enabled && !take && state_r == EIC_IDLE;
            state_r <= take ? EIC_ACK : EIC_IDLE;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            high_r <= 1'b0;
            vec_r  <= 8'h00;
        end else begin
            high_r <= any_hi;
            vec_r  <= win_vec;
        end
    end

    // Wake ignores global enable: the sleeping core cannot service anything yet
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= power_down && |(edge_hit & wmask);  // (see RQ16)
        end
    end

    assign sfr_hit      = sfr_addr == EIC_ADDR_POL || sfr_addr == EIC_ADDR_IE || sfr_addr == EIC_ADDR_IP;
    assign sfr_rdata    = (sfr_addr == EIC_ADDR_POL) ? {2'b00, ext_irq_pin, pol_r} :  // (see RQ12) (see RQ15)
                          (sfr_addr == EIC_ADDR_IE)  ? ie_r :
                          (sfr_addr == EIC_ADDR_IP)  ? ip_r : 8'h00;
    assign irq_req      = req_r;
    assign irq_vector   = vec_r;
    assign irq_high     = high_r;
    assign ext_edge_req = eflag_r[1:0];
    assign ext_pin_int  = pol_r[2:0] ^ ext_irq_pin;  // Inverted when polarity set (see RQ14)
    assign wake_req     = wake_r;

    // Internal nets stand in for state the pins cannot show
    a_global_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ18
        !$past(ie_r[EIC_GEN_BIT]) |-> !irq_req)
        else $error("request while globally disabled");

    a_take_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ18
        take |-> $past(ie_r[EIC_GEN_BIT]))
        else $error("taken while globally disabled");

    a_ext2_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ7
        (irq_req && irq_vector == EIC_VEC_BASE + 8'h30) |-> $past(ie_r[EIC_X2_BIT]))
        else $error("ext2 taken unmasked");

    a_pkt_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ8
        (irq_req && irq_vector == EIC_VEC_BASE + 8'h38) |-> $past(pkt_int_mask))
        else $error("pkt mask ignored");

    a_ext2_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ4
        (ext_irq_pin[2] == pol_r[2] && pin_d_r[2] != pol_r[2] && $stable(pol_r)) |=> eflag_r[2])
        else $error("ext2 edge missed");

    a_ext0_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ13
        (ext_irq_pin[0] == pol_r[0] && pin_d_r[0] != pol_r[0] && $stable(pol_r)) |=> eflag_r[0])
        else $error("ext0 edge missed");

    a_ext2_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ4
        (eflag_r[2] && !take) |=> eflag_r[2])
        else $error("ext2 flag lost");

    a_ext2_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ5
        (take && vec_r == EIC_VEC_BASE + 8'h30 && !edge_hit[2]) |=> !eflag_r[2])
        else $error("ext2 not cleared");

    a_ext0_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ3
        (take && vec_r == EIC_VEC_BASE && !edge_hit[0]) |=> !eflag_r[0])
        else $error("ext0 not cleared");

    a_ext1_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ3
        (take && vec_r == EIC_VEC_BASE + 8'h10 && !edge_hit[1]) |=> !eflag_r[1])
        else $error("ext1 not cleared");

    a_level_req: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ14
        (ie_r[EIC_GEN_BIT] && ie_r[0] && !timer_control_register_mode[EIC_TC_IT0] && ext_irq_pin[0] == pol_r[0]
         && state_r == EIC_IDLE && !take) |=> irq_req)
        else $error("level request missed");

    a_pin_read: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ12
        (sfr_addr == EIC_ADDR_POL) |-> sfr_rdata[5:3] == ext_irq_pin && sfr_rdata[7:6] == 2'b00)
        else $error("pin readback wrong");

    a_unmapped: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ11
        !sfr_hit |-> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");

    a_hit_decode: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ6
        (sfr_addr == EIC_ADDR_IE || sfr_addr == EIC_ADDR_IP) |-> sfr_hit)
        else $error("register not decoded");

    a_vec_range: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ2
        irq_req |-> irq_vector[2:0] == 3'b011 && irq_vector <= 8'h3B)
        else $error("bad vector");

    a_hi_first: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ10
        (irq_req && irq_high) |-> |($past(ip_r) & (8'h01 << irq_vector[5:3])))
        else $error("low won over high");

    a_high_order: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ17
        (irq_req && irq_high) |-> ($past(hi_set) & ((8'h01 << irq_vector[5:3]) - 8'h01)) == 8'h00)
        else $error("high level polled out of order");

    a_low_order: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ17
        (irq_req && !irq_high) |-> ($past(enabled) & ((8'h01 << irq_vector[5:3]) - 8'h01)) == 8'h00)
        else $error("low level polled out of order");

    a_req_drop: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ5
        take |=> !irq_req[*2])
        else $error("request not dropped after service");

    a_wake_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ16
        wake_req |-> $past(power_down))
        else $error("wake outside power down");

    a_wake_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ16
        (power_down && |(edge_hit & wmask)) |=> wake_req)
        else $error("wake edge missed");

    a_ie_write: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ6
        (sfr_we && sfr_addr == EIC_ADDR_IE) |=> ie_r == $past(sfr_wdata))
        else $error("enable write lost");

    a_ie_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ6
        (sfr_bit_we && !sfr_we && sfr_addr == EIC_ADDR_IE)
        |=> ((ie_r ^ $past(ie_r)) & ~(8'h01 << $past(sfr_bit_sel))) == 8'h00)
        else $error("enable bit write spilled");

    a_ip_write: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ9
        (sfr_we && sfr_addr == EIC_ADDR_IP) |=> ip_r == $past(sfr_wdata))
        else $error("priority write lost");

    a_ip_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ9
        (sfr_bit_we && !sfr_we && sfr_addr == EIC_ADDR_IP)
        |=> ((ip_r ^ $past(ip_r)) & ~(8'h01 << $past(sfr_bit_sel))) == 8'h00)
        else $error("priority bit write spilled");

    a_pol_bytes: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ11
        (sfr_bit_we && !sfr_we && sfr_addr == EIC_ADDR_POL) |=> $stable(pol_r))
        else $error("polarity took a bit write");

    a_pol_write: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see RQ13
        (sfr_we && sfr_addr == EIC_ADDR_POL) |=> pol_r == $past(sfr_wdata[2:0]))
        else $error("polarity write lost");

    a_ie_reset: assert property (@(posedge ref_clk)  // see RQ6
        $rose(rst_n) |-> ie_r == EIC_RST_IE && ip_r == EIC_RST_IP)
        else $error("reset values wrong");

    a_pol_reset: assert property (@(posedge ref_clk)  // see RQ11
        $rose(rst_n) |-> pol_r == EIC_RST_POL[2:0])
        else $error("polarity reset wrong");
endmodule // eic_ctrl

// ---- testbench/eic_core_model.sv ----
// Processor core model: takes pending interrupts after a chosen wait
`timescale 1ns/100ps
module eic_core_model (
    input  wire logic       ref_clk,    // Processor clock
    input  wire logic       rst_n,      // Core reset, active low
    input  wire logic       irq_req,    // Pending interrupt
    input  wire logic [7:0] irq_vector, // Vector of pending source
    input  wire logic [3:0] ack_wait,   // Cycles pending before taking
    output logic            irq_ack,    // Take strobe, one cycle
    output logic      [7:0] taken_vec,  // Vector of last taken interrupt
    output logic      [7:0] taken_cnt   // Interrupts taken so far
);
    logic [3:0] wait_r;
    wire        take = irq_req && !irq_ack && (wait_r >= ack_wait);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ack   <= 1'b0;
            wait_r    <= 4'h0;
            taken_vec <= 8'h00;
            taken_cnt <= 8'h00;
        end else begin
            // No ack in the cycle after an ack: the request is still high then, so !irq_ack blocks take
            irq_ack <= take;
            wait_r  <= (irq_req && !irq_ack && !take) ? wait_r + 4'h1 : 4'h0;
            if (take) begin
                taken_vec <= irq_vector;
                taken_cnt <= taken_cnt + 8'h01;
            end
        end
    end
endmodule // eic_core_model

// ---- testbench/ext_interrupt_controller_test.sv ----
// Self-checking bench for the external interrupt controller
`timescale 1ns/100ps
module ext_interrupt_controller_test;
    import eic_pkg::*;
    logic       ref_clk, rst_n, sfr_we, sfr_bit_we, t0_req, t1_req, pkt_req, pkt_mask, hit, irq_req, irq_ack;
    logic       pdown, bval, high, wake;
    logic [1:0] edge_req;
    logic [2:0] pins, pin_int, bsel;
    logic [3:0] timer_control_register, ack_wait;
    logic [7:0] addr, wdata, rdata, vec, taken_vec, taken_cnt, cnt0;
    int         mismatches, total_checks;
    eic_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .ext_irq_pin(pins), .timer0_req(t0_req), .timer1_req(t1_req),
        .timer2_req(1'b0), .serial_req(1'b0), .pkt_req(pkt_req), .pkt_int_mask(pkt_mask), .timer_control_register_mode(timer_control_register),
        .power_down(pdown), .sfr_addr(addr), .sfr_wdata(wdata), .sfr_we(sfr_we), .sfr_bit_we(sfr_bit_we),
        .sfr_bit_sel(bsel), .sfr_bit_val(bval), .sfr_rdata(rdata), .sfr_hit(hit), .irq_req(irq_req),
        .irq_vector(vec), .irq_high(high), .irq_ack(irq_ack), .ext_edge_req(edge_req), .ext_pin_int(pin_int),
        .wake_req(wake));
    eic_core_model core (.ref_clk(ref_clk), .rst_n(rst_n), .irq_req(irq_req), .irq_vector(vec),
        .ack_wait(ack_wait), .irq_ack(irq_ack), .taken_vec(taken_vec), .taken_cnt(taken_cnt));
    task automatic tick(input int n = 1);
        repeat (n) @(posedge ref_clk);
        #10;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick();
        addr = a;
        wdata = d;
        sfr_we = 1'b1;
        tick();
        sfr_we = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        #1;
        chk("sfr_rdata", exp, rdata);
    endtask
    // Count FF skips the count: level sources are taken again and again
    task automatic taken(input logic [7:0] n, input logic [7:0] v);
        tick(12);
        if (n != 8'hFF) chk("taken count", cnt0 + n, taken_cnt);
        chk("taken vector", v, taken_vec);
        cnt0 = taken_cnt;
    endtask
    task automatic t_regs;
        rd(EIC_ADDR_POL, 8'h38);
        rd(EIC_ADDR_IE, 8'h00);
        rd(EIC_ADDR_IP, 8'h00);
        rd(8'h93, 8'h00);
        chk("sfr_hit", 8'h00, {7'h0, hit});
        wr(EIC_ADDR_POL, 8'hFF);
        rd(EIC_ADDR_POL, 8'h3F);
        chk("ext_pin_int", 8'h00, {5'h0, pin_int});
        sfr_bit_we = 1'b1;
        tick();
        sfr_bit_we = 1'b0;
        pins = 3'b110;
        tick(3);
        rd(EIC_ADDR_POL, 8'h37);
        addr = EIC_ADDR_IE;
        bsel = 3'd7;
        bval = 1'b1;
        sfr_bit_we = 1'b1;
        tick();
        sfr_bit_we = 1'b0;
        rd(EIC_ADDR_IE, 8'h80);
        // Polarity and enable writes are left behind, so start clean
        rst_n = 1'b0;
        pins = 3'b111;
        tick(2);
        rst_n = 1'b1;
    endtask
    task automatic t_ext2;
        wr(EIC_ADDR_IE, 8'h40);
        pins = 3'b011;
        taken(8'h00, 8'h00);
        wr(EIC_ADDR_IE, 8'hC0);
        taken(8'h01, 8'h33);
        pins = 3'b111;
        wr(EIC_ADDR_POL, 8'h04);
        tick(12);
        cnt0 = taken_cnt;
        pins = 3'b011;
        taken(8'h00, 8'h33);
        ack_wait = 4'h4;
        pins = 3'b111;
        taken(8'h01, 8'h33);
    endtask
    task automatic t_level;
        timer_control_register = 4'h8;
        wr(EIC_ADDR_POL, 8'h00);
        wr(EIC_ADDR_IE, 8'h81);
        pins = 3'b110;
        taken(8'hFF, 8'h03);
        pins = 3'b111;
    endtask
    task automatic t_prio;
        wr(EIC_ADDR_IE, 8'h8A);
        t0_req = 1'b1;
        t1_req = 1'b1;
        taken(8'hFF, 8'h0B);
        wr(EIC_ADDR_IP, 8'h08);
        taken(8'hFF, 8'h1B);
        chk("irq_high", 8'h01, {7'h0, high});
        t1_req = 1'b0;
    endtask
    task automatic t_pkt;
        wr(EIC_ADDR_IE, 8'h82);
        wr(EIC_ADDR_IP, 8'h80);
        pkt_req = 1'b1;
        taken(8'hFF, 8'h0B);
        pkt_mask = 1'b1;
        taken(8'hFF, 8'h3B);
        chk("irq_high", 8'h01, {7'h0, high});
    endtask
    task automatic t_wake;
        pdown = 1'b1;
        wr(EIC_ADDR_IE, 8'h04);
        pins = 3'b101;
        tick();
        chk("wake_req", 8'h01, {7'h0, wake});
        chk("ext_edge_req", 8'h02, {6'h0, edge_req});
        tick();
        chk("wake_req", 8'h00, {7'h0, wake});
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        #400_000;
        mismatches++;
        final_report();
    end
    initial begin
        {rst_n, sfr_we, sfr_bit_we, t0_req, t1_req, pkt_req, pkt_mask} = '0;
        {pins, timer_control_register, ack_wait} = {3'b111, 4'hA, 4'h1};
        {pdown, bval, bsel} = {1'b0, 1'b0, 3'd1};
        {addr, wdata, cnt0, mismatches, total_checks} = '0;
        tick(5);
        rst_n = 1'b1;
        t_regs();
        t_ext2();
        t_level();
        t_prio();
        t_pkt();
        t_wake();
        final_report();
    end
endmodule // ext_interrupt_controller_test
